// >>> include/wcs_params.svh
/*
  Offsets, field positions, reset values and timing counts for the wake input
  and cyclic sense timer block.
  Assumes a 10 MHz core clock; all counts are derived from times in microseconds.
*/
`ifndef WCS_PARAMS_SVH
`define WCS_PARAMS_SVH

// ==========================================================================
// Register offsets (7-bit register address)
`define WCS_ADDR_PULL        7'h08
`define WCS_ADDR_FILTER      7'h09
`define WCS_ADDR_TIMER_A     7'h0C
`define WCS_ADDR_TIMER_B     7'h0D
`define WCS_ADDR_WAKE_EN     7'h06
`define WCS_ADDR_HS_CLR      7'h14

// ==========================================================================
// Field positions and reset value
`define WCS_FLD_ON_HI        6
`define WCS_FLD_ON_LO        4
`define WCS_FLD_PER_HI       2
`define WCS_FLD_PER_LO       0
`define WCS_FLD_WK_A         6
`define WCS_FLD_WK_B         7
`define WCS_RESET_VALUE      8'h00
`define WCS_PULL_MASK        8'h3F
`define WCS_TIMER_MASK       8'h77

// ==========================================================================
// Timing: times in microseconds, clock in MHz
`define WCS_CLK_MHZ          10
`define WCS_FILT_SHORT_US    16
`define WCS_FILT_LONG_US     64
`define WCS_FILT_SHORT_CYC   (`WCS_FILT_SHORT_US * `WCS_CLK_MHZ)
`define WCS_FILT_LONG_CYC    (`WCS_FILT_LONG_US * `WCS_CLK_MHZ)
`define WCS_ON_1_US          100
`define WCS_ON_2_US          300
`define WCS_ON_3_US          1000
`define WCS_ON_4_US          10000
`define WCS_ON_5_US          20000
`define WCS_PER_0_US         10000
`define WCS_PER_1_US         20000
`define WCS_PER_2_US         50000
`define WCS_PER_3_US         100000
`define WCS_PER_4_US         200000
`define WCS_PER_5_US         1000000
`define WCS_PER_6_US         2000000

`endif

// >>> include/wcs_pkg.sv
/*
  Types for the wake input and cyclic sense timer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wcs_pkg;

  // ========================================================================
  // Pull selection codes
  typedef enum logic [1:0] {
    WCS_PULL_NONE = 2'h0,
    WCS_PULL_DOWN = 2'h1,
    WCS_PULL_UP   = 2'h2,
    WCS_PULL_AUTO = 2'h3
  } wcs_pull_t;

  // Filter codes
  typedef enum logic [1:0] {
    WCS_FLT_STATIC_SHORT = 2'h0,
    WCS_FLT_STATIC_LONG  = 2'h1,
    WCS_FLT_CYCLIC_A     = 2'h2,
    WCS_FLT_CYCLIC_B     = 2'h3
  } wcs_filter_t;

  // Timer phase, Gray-coded along stop -> on -> off -> on
  typedef enum logic [1:0] {
    WCS_T_STOP = 2'b00,
    WCS_T_ON   = 2'b01,
    WCS_T_OFF  = 2'b11
  } wcs_tstate_t;

endpackage

// >>> hw/wcs_wake_timers.sv
/*
  Wake input configuration and two cyclic sense timers.
  Holds the pull, filter and two timer registers, runs both timers, drives the
  timer outputs toward the high-side switches and filters the wake inputs.
  Assumes a simple synchronous register port from the serial interface, that
  analog pull control is driven from the pull outputs, and inputs synchronous
  to CLK_IN.
*/
// ==========================================================================
// Notes on behaviour
// - Two-bit pull code: none, down, up, auto
// - Pull fields: third 5:4, second 3:2, first 1:0
// - Filter 00 static 16us, 01 static 64us
// - Filter 10/11 cyclic on timer a/b, 16us
// - Filter fields: third 5:4, second 3:2, first 1:0
// - On-time codes 1..5: 0.1,0.3,1,10,20 ms
// - On-time 000 stops timer, output low
// - On-time 110 stops timer, output high; 111 reserved
// - Period codes 0..6: 10ms to 2s
// - On-time bits 6:4, period 2:0, 7/3 reserved
// - Writing running on-time starts timer at once
// - Restart switch clear with cyclic clears timer
// - Cyclic wake and cyclic sense run together
// - Reserved bits read back as zero
// - Reset clears all five registers
// - Per-timer enable selects cyclic wake source
`timescale 1ns/10ps
`include "wcs_params.svh"

module wcs_wake_timers
  import wcs_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RESET_N_IN,
  // Register port
  input  wire logic       REG_WR_IN,
  input  wire logic [6:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  output logic      [7:0] REG_RDATA_OUT,
  // Restart mode clearing of the high-side switch settings
  input  wire logic       HS_CLEAR_IN,
  input  wire logic       HS_CYCLIC_IN,
  // Wake inputs, after comparator
  input  wire logic [2:0] WAKE_IN,
  // Outputs
  output logic      [1:0] TIMER_HS_OUT,
  output logic      [5:0] PULL_SEL_OUT,
  output logic      [2:0] WAKE_LEVEL_OUT,
  output logic      [2:0] WAKE_EVENT_OUT,
  output logic      [1:0] CYCLIC_WAKE_OUT
);

  localparam int CW = 25;                   // Wide enough for 2 s at 10 MHz
  // Checks sample on the core clock and stand down while reset is held
  default clocking chk_clk @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // ========================================================================
  // Registers
  logic [7:0] pull_cfg, next_pull_cfg;      // Pull selections
  logic [7:0] flt_cfg, next_flt_cfg;        // Filter selections
  logic [7:0] tmr_cfg [2];                  // Timer a/b configuration
  logic [7:0] next_tmr_cfg [2];
  logic [1:0] wake_en, next_wake_en;        // Timer wake enables

  // Register next values, reserved bits masked off on write
  always_comb begin
    next_pull_cfg = pull_cfg;
    next_flt_cfg  = flt_cfg;
    next_tmr_cfg  = tmr_cfg;
    next_wake_en  = wake_en;
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        `WCS_ADDR_PULL:    next_pull_cfg = REG_WDATA_IN & `WCS_PULL_MASK;
        `WCS_ADDR_FILTER:  next_flt_cfg  = REG_WDATA_IN & `WCS_PULL_MASK;
        `WCS_ADDR_TIMER_A: next_tmr_cfg[0] = REG_WDATA_IN & `WCS_TIMER_MASK;
        `WCS_ADDR_TIMER_B: next_tmr_cfg[1] = REG_WDATA_IN & `WCS_TIMER_MASK;
        `WCS_ADDR_WAKE_EN: next_wake_en = {REG_WDATA_IN[`WCS_FLD_WK_B],
                                           REG_WDATA_IN[`WCS_FLD_WK_A]};
        default: ;                          // Other addresses belong elsewhere
      endcase
    end
    // Switch settings cleared while cyclic sense runs: drop settings of each timer a cyclic filter uses
    if (HS_CLEAR_IN && HS_CYCLIC_IN) begin
      for (int i = 0; i < 2; i++) begin
        if (flt_cfg[1:0] == {1'b1, i[0]} || flt_cfg[3:2] == {1'b1, i[0]} ||
            flt_cfg[5:4] == {1'b1, i[0]}) begin
          next_tmr_cfg[i] = `WCS_RESET_VALUE;
        end
      end
    end
    if (!RESET_N_IN) begin
      next_pull_cfg = `WCS_RESET_VALUE;
      next_flt_cfg  = `WCS_RESET_VALUE;
      next_tmr_cfg[0] = `WCS_RESET_VALUE;
      next_tmr_cfg[1] = `WCS_RESET_VALUE;
      next_wake_en  = 2'h0;
    end
  end

  // Register storage
  always_ff @(posedge CLK_IN) begin
    pull_cfg <= next_pull_cfg;
    flt_cfg  <= next_flt_cfg;
    tmr_cfg  <= next_tmr_cfg;
    wake_en  <= next_wake_en;
  end

  // Read data, registered; unmapped addresses read zero
  logic [7:0] next_rdata;
  always_comb begin
    unique case (REG_ADDR_IN)
      `WCS_ADDR_PULL:    next_rdata = pull_cfg;
      `WCS_ADDR_FILTER:  next_rdata = flt_cfg;
      `WCS_ADDR_TIMER_A: next_rdata = tmr_cfg[0];
      `WCS_ADDR_TIMER_B: next_rdata = tmr_cfg[1];
      `WCS_ADDR_WAKE_EN: next_rdata = {wake_en, 6'h00};
      default:           next_rdata = 8'h00;
    endcase
    if (!RESET_N_IN) next_rdata = 8'h00;
  end

  // ========================================================================
  // Timing lookups
  function automatic logic [CW-1:0] on_cycles(input logic [2:0] code);
    unique case (code)
      3'h1:    on_cycles = CW'(`WCS_ON_1_US * `WCS_CLK_MHZ);
      3'h2:    on_cycles = CW'(`WCS_ON_2_US * `WCS_CLK_MHZ);
      3'h3:    on_cycles = CW'(`WCS_ON_3_US * `WCS_CLK_MHZ);
      3'h4:    on_cycles = CW'(`WCS_ON_4_US * `WCS_CLK_MHZ);
      3'h5:    on_cycles = CW'(`WCS_ON_5_US * `WCS_CLK_MHZ);
      default: on_cycles = CW'(0);
    endcase
  endfunction

  function automatic logic [CW-1:0] per_cycles(input logic [2:0] code);
    unique case (code)
      3'h0:    per_cycles = CW'(`WCS_PER_0_US * `WCS_CLK_MHZ);
      3'h1:    per_cycles = CW'(`WCS_PER_1_US * `WCS_CLK_MHZ);
      3'h2:    per_cycles = CW'(`WCS_PER_2_US * `WCS_CLK_MHZ);
      3'h3:    per_cycles = CW'(`WCS_PER_3_US * `WCS_CLK_MHZ);
      3'h4:    per_cycles = CW'(`WCS_PER_4_US * `WCS_CLK_MHZ);
      3'h5:    per_cycles = CW'(`WCS_PER_5_US * `WCS_CLK_MHZ);
      // Reserved period code treated as the longest period
      default: per_cycles = CW'(`WCS_PER_6_US * `WCS_CLK_MHZ);
    endcase
  endfunction

  // ========================================================================
  // Timers
  wcs_tstate_t   tst [2], next_tst [2];     // Timer phase
  logic [CW-1:0] tcnt [2], next_tcnt [2];   // Cycles into the period
  logic [1:0]    hs, next_hs;               // Timer outputs
  logic [1:0]    on_end, next_on_end;       // Pulse at end of on-time
  logic [1:0]    on_wr;                     // On-time field written

  assign on_wr = {REG_WR_IN && REG_ADDR_IN == `WCS_ADDR_TIMER_B,
                  REG_WR_IN && REG_ADDR_IN == `WCS_ADDR_TIMER_A};

  // Timer next state; any write of a running code restarts the period
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [2:0] onc;
      onc = next_tmr_cfg[i][`WCS_FLD_ON_HI:`WCS_FLD_ON_LO];
      next_tst[i]    = tst[i];
      next_tcnt[i]   = tcnt[i] + CW'(1);
      next_hs[i]     = hs[i];
      next_on_end[i] = 1'b0;
      if (onc == 3'h0 || onc == 3'h6 || onc == 3'h7) begin
        next_tst[i]  = WCS_T_STOP;
        next_tcnt[i] = CW'(0);
        next_hs[i]   = (onc == 3'h6);
      end else if (on_wr[i] || tst[i] == WCS_T_STOP) begin
        next_tst[i]  = WCS_T_ON;
        next_tcnt[i] = CW'(0);
        next_hs[i]   = 1'b1;
      end else begin
        unique case (tst[i])
          WCS_T_ON: begin
            if (tcnt[i] >= on_cycles(onc) - CW'(1)) begin
              next_tst[i]    = WCS_T_OFF;
              next_hs[i]     = 1'b0;
              next_on_end[i] = 1'b1;
            end
          end
          default: begin
            if (tcnt[i] >= per_cycles(next_tmr_cfg[i][2:0]) - CW'(1)) begin
              next_tst[i]  = WCS_T_ON;
              next_tcnt[i] = CW'(0);
              next_hs[i]   = 1'b1;
            end
          end
        endcase
      end
      if (!RESET_N_IN) begin
        next_tst[i]  = WCS_T_STOP;
        next_tcnt[i] = CW'(0);
        next_hs[i]   = 1'b0;
      end
    end
  end

  // Timer registers
  always_ff @(posedge CLK_IN) begin
    tst    <= next_tst;
    tcnt   <= next_tcnt;
    hs     <= next_hs;
    on_end <= next_on_end;
  end

  // ========================================================================
  // Wake filters: static counters, or one 16 us window at each on-time end
  logic [9:0] fcnt [3], next_fcnt [3];      // Stable-level counters
  logic [2:0] lvl, next_lvl;                // Filtered levels
  logic [2:0] evt, next_evt;                // Level change pulses
  logic [2:0] prev, next_prev;              // Last sampled input
  logic [2:0] arm, next_arm;                // Cyclic sample window open
  logic [1:0] cwk, next_cwk;                // Cyclic wake pulses

  // Filter next state
  always_comb begin
    for (int w = 0; w < 3; w++) begin
      logic [1:0] fc;
      logic [9:0] need;
      fc = flt_cfg[2*w +: 2];
      need = (fc == WCS_FLT_STATIC_LONG) ? 10'(`WCS_FILT_LONG_CYC)
                                         : 10'(`WCS_FILT_SHORT_CYC);
      next_prev[w] = WAKE_IN[w];
      next_lvl[w]  = lvl[w];
      next_evt[w]  = 1'b0;
      next_arm[w]  = arm[w];
      next_fcnt[w] = (WAKE_IN[w] != prev[w]) ? 10'h000 : fcnt[w] + 10'h001;
      if (fc[1]) begin
        // Cyclic: open window at the selected timer's on-time end
        if (on_end[fc[0]]) begin
          next_arm[w]  = 1'b1;
          next_fcnt[w] = 10'h000;
        end else if (arm[w] && WAKE_IN[w] != prev[w]) begin
          next_arm[w]  = 1'b0;                                         // Unstable: discard
        end
      end else begin
        next_arm[w] = 1'b0;
      end
      if (fcnt[w] >= need - 10'h001 && WAKE_IN[w] == prev[w] &&
          (!fc[1] || arm[w])) begin
        next_arm[w] = 1'b0;
        next_lvl[w] = WAKE_IN[w];
        next_evt[w] = (WAKE_IN[w] != lvl[w]);
      end
      if (!RESET_N_IN) begin
        next_prev[w] = 1'b0;
        next_lvl[w]  = 1'b0;
        next_evt[w]  = 1'b0;
        next_arm[w]  = 1'b0;
        next_fcnt[w] = 10'h000;
      end
    end
    // Cyclic wake runs alongside cyclic sense on the same timer
    next_cwk = RESET_N_IN ? (next_on_end & wake_en) : 2'h0;
  end

  // Filter registers
  always_ff @(posedge CLK_IN) begin
    fcnt <= next_fcnt;
    lvl  <= next_lvl;
    evt  <= next_evt;
    prev <= next_prev;
    arm  <= next_arm;
    cwk  <= next_cwk;
    REG_RDATA_OUT <= next_rdata;
  end

  // Outputs straight from flip-flops
  assign TIMER_HS_OUT    = hs;              // Software routes these to switches
  assign PULL_SEL_OUT    = pull_cfg[5:0];
  assign WAKE_LEVEL_OUT  = lvl;
  assign WAKE_EVENT_OUT  = evt;
  assign CYCLIC_WAKE_OUT = cwk;

  // ========================================================================
  // Checks
  property p_stop_low;
    tmr_cfg[0][6:4] == 3'h0 |-> !TIMER_HS_OUT[0];
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("timer a not low when stopped");
  property p_stop_high;
    tmr_cfg[1][6:4] == 3'h6 |-> TIMER_HS_OUT[1];
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("timer b not high when held");
  property p_reserved_zero;
    pull_cfg[7:6] == 2'h0 && flt_cfg[7:6] == 2'h0 &&
      ((tmr_cfg[0] | tmr_cfg[1]) & 8'h88) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");
  sequence s_start_a;
    on_wr[0] && REG_WDATA_IN[6:4] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5} && !HS_CLEAR_IN;
  endsequence
  property p_start;
    s_start_a |=> TIMER_HS_OUT[0] && tcnt[0] == CW'(0);
  endproperty
  a_start: assert property (p_start)
    else $error("timer a did not start on write");
  property p_on_len;
    $rose(on_end[0]) && tmr_cfg[0][6:4] == 3'h1 |->
      $past(tcnt[0]) == CW'(`WCS_ON_1_US * `WCS_CLK_MHZ - 1);
  endproperty
  a_on_len: assert property (p_on_len)
    else $error("timer a 0.1 ms on-time wrong");
  property p_reset_clear;
    !$past(RESET_N_IN) |-> pull_cfg == 8'h00 && flt_cfg == 8'h00 && tmr_cfg[1] == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear registers");
  property p_cyc_wake;
    on_end[1] |-> CYCLIC_WAKE_OUT[1] == $past(wake_en[1]);
  endproperty
  a_cyc_wake: assert property (p_cyc_wake)
    else $error("cyclic wake does not follow its enable");
  property p_restart_clr;
    HS_CLEAR_IN && HS_CYCLIC_IN && flt_cfg[1:0] == 2'h2 |=> tmr_cfg[0] == 8'h00;
  endproperty
  a_restart_clr: assert property (p_restart_clr)
    else $error("timer a not cleared on restart");
  property p_period;
    $rose(TIMER_HS_OUT[0]) && $past(tst[0]) == WCS_T_OFF && !$past(on_wr[0]) &&
      tmr_cfg[0][2:0] == 3'h0 |-> $past(tcnt[0]) == CW'(`WCS_PER_0_US * `WCS_CLK_MHZ - 1);
  endproperty
  a_period: assert property (p_period)
    else $error("timer a period wrong");

endmodule

// >>> testbench/wcs_wake_switch.sv
/*
  Model of the switches and wiring on the three wake inputs.
  Assumes the pull codes from the block shape the level of an open line.
*/
`timescale 1ns/10ps

module wcs_wake_switch (
  // Clock and commands
  input  wire logic       clk_in,
  input  wire logic [2:0] closed_in,
  input  wire logic [5:0] pull_in,
  // Wake lines
  output logic      [2:0] line_out
);
  logic flip = 1'b0; // Pattern of a floating line

  // ========================================================================
  // Floating pattern
  // An undriven line must not look like a clean level to the filters
  always_ff @(posedge clk_in) begin
    flip <= ~flip;
  end

  // ========================================================================
  // Line levels
  // A closed switch ties to battery; an open line follows its pull
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (pull_in[2*i+:2])
        2'h1:    line_out[i] = closed_in[i];        // Pull-down
        2'h2:    line_out[i] = 1'b1;                // Pull-up
        default: line_out[i] = closed_in[i] | flip; // No fixed level
      endcase
    end
  end
endmodule

// >>> testbench/tb.sv
/*
  Self-checking bench for the wake input and cyclic timer block.
  Assumes the design parameter header and the wake switch model.
*/
`timescale 1ns/10ps
`include "wcs_params.svh"

module tb;
  // ========================================================================
  // Stimulus and observed signals
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        wr     = 1'b0;
  logic [6:0]  addr   = 7'h00;
  logic [7:0]  wdata  = 8'h00;
  logic        hs_clr = 1'b0;
  logic        hs_cyc = 1'b0;
  logic [2:0]  closed = 3'h0;
  logic        rd_tag = 1'b0;
  logic        rd_d   = 1'b0;
  logic [2:0]  wake;
  logic [7:0]  rdata;
  logic [1:0]  hs_out;
  logic [5:0]  pull;
  logic [2:0]  lvl;
  logic [2:0]  evt;
  logic [1:0]  cwake;
  logic [14:0] exp_q[$];    // Read notes: address and expected data
  logic [14:0] note;
  logic [7:0]  v;
  int          err_total   = 0;
  int          comparisons = 0;
  int          seed        = 78319;
  int          ev[3]       = '{0, 0, 0}; // Level change pulses seen
  int          cw[2]       = '{0, 0};    // Cyclic wake pulses seen
  int          t0, t1, e0, e1, b;
  localparam int FS = `WCS_FILT_SHORT_CYC;
  localparam int FL = `WCS_FILT_LONG_CYC;
  logic [6:0]  regs[5] = '{7'h08, 7'h09, 7'h0C, 7'h0D, 7'h06};
  logic [7:0]  msk[5]  = '{8'h3F, 8'h3F, 8'h77, 8'h77, 8'hC0};
  int          on_cyc[4] = '{0, `WCS_ON_1_US * `WCS_CLK_MHZ,
                             `WCS_ON_2_US * `WCS_CLK_MHZ, `WCS_ON_3_US * `WCS_CLK_MHZ};

  wcs_wake_timers u_dut (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .REG_WR_IN(wr), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .HS_CLEAR_IN(hs_clr),
    .HS_CYCLIC_IN(hs_cyc), .WAKE_IN(wake), .TIMER_HS_OUT(hs_out),
    .PULL_SEL_OUT(pull), .WAKE_LEVEL_OUT(lvl), .WAKE_EVENT_OUT(evt),
    .CYCLIC_WAKE_OUT(cwake));

  wcs_wake_switch u_sw (.clk_in(clk), .closed_in(closed), .pull_in(pull), .line_out(wake));

  // ========================================================================
  // Clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end

  // ========================================================================
  // Compare and report
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d mismatches, %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Read data lands one cycle after the address; oldest note is taken then
  always @(posedge clk) begin
    rd_d <= rd_tag;
    for (int i = 0; i < 3; i++) begin
      if (evt[i] === 1'b1) ev[i]++;
    end
    for (int i = 0; i < 2; i++) begin
      if (cwake[i] === 1'b1) cw[i]++;
    end
    if (rd_d) begin
      note = exp_q.pop_front();
      chk($sformatf("read of %0h", note[14:8]), note[7:0], rdata);
    end
  end

  // ========================================================================
  // Register port cycles
  task automatic wr_reg(logic [6:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [6:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_tag <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge clk);
    rd_tag <= 1'b0;
  endtask

  task automatic clr_pulse(logic cyc);
    @(posedge clk);
    hs_cyc <= cyc;
    hs_clr <= 1'b1;
    @(posedge clk);
    hs_clr <= 1'b0;
  endtask

  // Counts cycles the timer output stays high; bounded so a stuck output ends the run
  task automatic on_len(int t, int e);
    int n;
    n = 0;
    #1;
    while (hs_out[t] === 1'b1 && n < 30000) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk("on-time cycles", e, n);
    if (n == 30000) finish_test();
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    rd_reg(7'h10, 8'h00);
    $display("Reset values done");
    foreach (regs[i]) wr_reg(regs[i], 8'hFF);
    wr_reg(7'h10, 8'hFF);
    #1 chk("stop on reserved code", 0, hs_out);
    foreach (regs[i]) rd_reg(regs[i], msk[i]);
    rd_reg(7'h10, 8'h00);
    foreach (regs[i]) wr_reg(regs[i], 8'h00);
    $display("Reserved bits done");
    // Random pull and filter codes, eight random values for each register
    repeat (8) begin
      v = 8'($random(seed));
      wr_reg(7'h08, v);
      wr_reg(7'h09, ~v);
      #1 chk("pull select", v[5:0], pull);
      rd_reg(7'h08, v & 8'h3F);
      rd_reg(7'h09, ~v & 8'h3F);
    end
    $display("Pull and filter fields done");
    wr_reg(7'h0C, 8'h60);
    #1 chk("timer a high stop", 1, hs_out[0]);
    wr_reg(7'h0D, 8'h60);
    #1 chk("timer b high stop", 1, hs_out[1]);
    wr_reg(7'h0C, 8'h00);
    #1 chk("timer a low stop", 0, hs_out[0]);
    wr_reg(7'h0D, 8'h00);
    $display("Stop codes done");
    // Cyclic sense on both timers with cyclic wake enabled as well
    wr_reg(7'h08, 8'h15);
    wr_reg(7'h09, 8'h0E);
    wr_reg(7'h06, 8'hC0);
    hs_cyc <= 1'b1; // Timer outputs count as assigned to a switch
    closed <= 3'h3;
    for (int c = 1; c <= 3; c++) begin
      if (c == 3) wr_reg(7'h06, 8'h80); // Timer a wake off for the last pass
      b = cw[c % 2 == 0];
      wr_reg((c % 2 == 0) ? 7'h0D : 7'h0C, {1'b0, 3'(c), 4'h0});
      on_len(c % 2 == 0, on_cyc[c]);
      repeat (FS + 40) @(posedge clk);
      chk("cyclic wake pulses", b + (c < 3), cw[c % 2 == 0]);
      #1 chk("off phase", 0, hs_out[c % 2 == 0]);
      wr_reg((c % 2 == 0) ? 7'h0D : 7'h0C, 8'h00);
    end
    chk("cyclic sense levels", 2'h3, lvl[1:0]);
    $display("Cyclic timers done");
    // Static filters: first input short, second input long
    closed <= 3'h0;
    wr_reg(7'h09, 8'h04);
    repeat (FL + 40) @(posedge clk);
    chk("idle levels", 0, lvl);
    e0 = ev[0];
    e1 = ev[1];
    t0 = 0;
    t1 = 0;
    @(posedge clk);
    closed <= 3'h3;
    for (int k = 1; k <= FL + 40; k++) begin
      @(posedge clk);
      #1;
      if (lvl[0] === 1'b1 && t0 == 0) t0 = k;
      if (lvl[1] === 1'b1 && t1 == 0) t1 = k;
    end
    chk("short filter delay", 1, t0 >= FS && t0 < FS + 8);
    chk("long filter delay", 1, t1 >= FL && t1 < FL + 8);
    chk("level events", 2, ev[0] - e0 + ev[1] - e1);
    $display("Static filters done");
    // Restart clearing only with cyclic sense active
    closed <= 3'h0;
    wr_reg(7'h09, 8'h02);
    wr_reg(7'h0C, 8'h12);
    wr_reg(7'h0D, 8'h23);
    clr_pulse(1'b0);
    rd_reg(7'h0C, 8'h12);
    clr_pulse(1'b1);
    rd_reg(7'h0C, 8'h00);
    rd_reg(7'h0D, 8'h23);
    #1 chk("cleared timer output", 0, hs_out[0]);
    repeat (3) @(posedge clk);
    $display("Restart clear done");
    // Reset in mid-run, with timer b running and pulls set
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    #1 chk("outputs after reset", 0, {hs_out, pull, lvl});
    repeat (3) @(posedge clk);
    $display("Mid-run reset done");
    finish_test();
  end
endmodule
